// File: bench/remote_dev.sv
`timescale 1ns/1ps
module remote_dev (
  // clock
  input wire logic aclk,
  // serial line
  output logic line
);
  initial line = 1'b1;
  // exact rate, no error
  task automatic send(input logic [7:0] b, input int p);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (p) @(posedge aclk);
    end
  endtask : send
  task automatic brk(input int n);
    line <= 1'b0;
    repeat (n) @(posedge aclk);
    line <= 1'b1;
  endtask : brk
endmodule : remote_dev

// File: bench/serial_autorate_port_tb.sv
`timescale 1ns/1ps
module serial_autorate_port_tb;
  import serial_pkg::*;
  logic aclk, aresetn, rxd_i, txd_o, txd_oe, dir;
  wire logic txd_i;
  axil_req_t req;
  axil_rsp_t rsp;
  int n_mismatch, compares, cyc;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] cap;
  // wr, addr, wdata, expected read, expected resp
  int rows[6][5] = '{'{0, 'h10, 0, 'h1000, 0}, '{0, 'h04, 0, 0, 0}, '{0, 'h08, 0, 0, 0},
    '{1, 'h10, 'h100, 'h100, 0}, '{1, 'h04, 2, 2, 0}, '{1, 'h20, 5, 0, 2}};
  // mode, bit period, sync byte, expected divisor, sync error
  int ac[4][5] = '{'{2, 24, 'h55, 'hC0, 0}, '{2, 8, 'h55, 'hC0, 0},
    '{3, 16, 'h55, 'h80, 0}, '{3, 16, 'h7D, 'h80, 1}};
  assign txd_i = txd_oe ? txd_o : 1'b1;
  serial_autorate_port dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .rxd_i(rxd_i), .txd_i(txd_i), .txd_o(txd_o), .txd_oe(txd_oe),
    .transceiver_direction_output(dir));
  remote_dev rem_u (.aclk(aclk), .line(rxd_i));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  // samples the resolved line in mid-bit
  task automatic txcap(input int p);
    int k;
    k = 0;
    while (txd_i !== 1'b0 && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    repeat (p / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (p) @(posedge aclk);
      cap[i] = txd_i;
    end
  endtask : txcap
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    req = '0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][0] != 0) begin
        wr(8'(rows[i][1]), 32'(rows[i][2]), r);
        chk(32'(r), 32'(rows[i][4]));
      end
      rd(8'(rows[i][1]), d, r);
      chk(d, 32'(rows[i][3]));
      chk(32'(r), 32'(rows[i][4]));
    end
    wr(OFS_FIRST_CTRL, 32'h3, r);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_SECOND_CTRL, m ? 32'h1C : 32'h18, r);
      fork
        rem_u.send(8'h00, 32);
      join_none
      wr(OFS_DATA, 32'hA5, r);
      txcap(32);
      chk(32'(cap), 32'hA5);
      repeat (120) @(posedge aclk);
      chk(32'(dir), 32'h0);
      rd(OFS_DATA, d, r);
      chk(d, 32'h1A5);
    end
    wr(OFS_FIRST_CTRL, 32'h0, r);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_SECOND_CTRL, 32'(8 | m), r);
      rem_u.send(8'(8'h3C ^ m), m ? 16 : 32);
      repeat (40) @(posedge aclk);
      rd(OFS_DATA, d, r);
      chk(d, 32'(32'h13C ^ m));
    end
    rem_u.brk(3);
    repeat (400) @(posedge aclk);
    rd(OFS_DATA, d, r);
    chk(32'(d[8]), 32'h0);
    foreach (ac[i]) begin
      wr(OFS_SECOND_CTRL, 32'(8 | ac[i][0]), r);
      rem_u.brk(20);
      repeat (64) @(posedge aclk);
      rem_u.send(8'(ac[i][2]), ac[i][1]);
      if (ac[i][4] != 0) begin
        rem_u.send(8'hFF, 16);
        rem_u.send(8'hFF, 16);
      end
      repeat (40) @(posedge aclk);
      rd(OFS_DIVISOR, d, r);
      chk(d, 32'(ac[i][3]));
      rd(OFS_STATUS, d, r);
      chk(32'(d[3]), 32'(ac[i][4]));
      wr(OFS_STATUS, 32'h8, r);
      wr(OFS_SECOND_CTRL, 32'h08, r);
    end
    wr(OFS_SECOND_CTRL, 32'hA, r);
    wr(OFS_STATUS, 32'h4, r);
    rd(OFS_STATUS, d, r);
    chk(32'(d[2]), 32'h1);
    rem_u.brk(4);
    repeat (64) @(posedge aclk);
    rem_u.send(8'h55, 20);
    repeat (40) @(posedge aclk);
    rd(OFS_DIVISOR, d, r);
    chk(d, 32'hA0);
    rd(OFS_STATUS, d, r);
    chk(32'(d[2]), 32'h0);
    print_verdict();
  end
endmodule : serial_autorate_port_tb

// File: bench/serial_port_sva.sv
`timescale 1ns/1ps
module serial_port_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire serial_pkg::axil_req_t axi_req,
  input wire serial_pkg::axil_rsp_t axi_rsp,
  // pins
  input wire logic rxd_i,
  input wire logic txd_i,
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire logic transceiver_direction_output
);
  import serial_pkg::*;
  logic [4:0] fc_r;
  logic [4:0] sc_r;
  logic wt;
  logic dir;
  assign wt = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  assign dir = transceiver_direction_output;
  // level on the pin, pull-up when released
  logic pin_lvl;
  assign pin_lvl = txd_oe ? txd_o : 1'b1;
  // shadow of the two control words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_r <= '0;
      sc_r <= '0;
    end else if (wt && axi_req.awaddr == OFS_FIRST_CTRL) begin
      fc_r <= axi_req.wdata[4:0];
    end else if (wt && axi_req.awaddr == OFS_SECOND_CTRL) begin
      sc_r <= axi_req.wdata[4:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wtake;
    wt;
  endsequence
  sequence s_rtake;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  AST_B_AFTER_W: assert property (s_wtake |-> ##[1:2] axi_rsp.bvalid)
    else $error("no write response");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("bvalid dropped");
  AST_R_AFTER_AR: assert property (s_rtake |=> axi_rsp.rvalid)
    else $error("no read data");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=> $stable(axi_rsp.rdata))
    else $error("rdata moved");
  AST_UNMAPPED: assert property ((s_rtake and (axi_req.araddr > OFS_DIVISOR)) |=>
    axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_OD_NO_HIGH: assert property (sc_r[2] && $past(sc_r[2], 2) |-> !txd_o)
    else $error("pin driven high in open drain");
  AST_DIR_OFF: assert property (!fc_r[1] && !$past(fc_r[1], 2) |-> !dir)
    else $error("direction high while disabled");
  AST_DIR_FRAME: assert property (fc_r[1] && !sc_r[2] && txd_oe && !txd_o |-> dir)
    else $error("direction low in frame");
  AST_DIR_LEAD: assert property (fc_r[1] && $fell(pin_lvl) |-> $past(dir, 2))
    else $error("direction late");
endmodule : serial_port_sva
bind serial_autorate_port serial_port_sva chk_u (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .rxd_i(rxd_i), .txd_i(txd_i), .txd_o(txd_o),
  .txd_oe(txd_oe), .transceiver_direction_output(transceiver_direction_output));

// File: common/serial_pkg.sv
package serial_pkg;

  localparam int ADDR_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FIRST_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SECOND_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DIVISOR = 8'h10;

  typedef enum logic [2:0] {
    SEL_DATA = 3'h0,
    SEL_FIRST_CTRL = 3'h1,
    SEL_SECOND_CTRL = 3'h2,
    SEL_STATUS = 3'h3,
    SEL_DIVISOR = 3'h4,
    SEL_NONE = 3'h7
  } reg_sel_t;

  // first_control_register fields
  localparam int LOOP_BACK_BIT = 0;
  localparam int XCVR_EN_BIT = 1;
  // second_control_register fields
  localparam int RX_MODE_LSB = 0;
  localparam int OPEN_DRAIN_BIT = 2;
  localparam int RX_EN_BIT = 3;
  localparam int TX_EN_BIT = 4;
  // status fields
  localparam int ST_RX_VALID_BIT = 0;
  localparam int ST_TX_BUSY_BIT = 1;
  localparam int ST_WAIT_BREAK_BIT = 2;
  localparam int ST_SYNC_ERR_BIT = 3;
  localparam int ST_FRAME_ERR_BIT = 4;
  // data read: valid flag above the byte
  localparam int DATA_VALID_BIT = 8;

  localparam logic [4:0] FIRST_CTRL_RESET = 5'h00;
  localparam logic [4:0] SECOND_CTRL_RESET = 5'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h1000;

  // receive_mode_field encodings
  localparam logic [1:0] RECEIVE_MODE_FIELD_NORMAL = 2'h0;
  localparam logic [1:0] RECEIVE_MODE_FIELD_DOUBLE = 2'h1;
  localparam logic [1:0] RECEIVE_MODE_FIELD_GENERIC_AUTO = 2'h2;
  localparam logic [1:0] RECEIVE_MODE_FIELD_LIN_AUTO = 2'h3;

  // sampling
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [16:0] ACC_STEP = 17'h00080;

  // auto-rate
  localparam logic [3:0] BREAK_MIN = 4'hC;
  localparam logic [2:0] SYNC_FALLS = 3'h4;
  localparam logic [16:0] RATE_MIN = 17'h00064;
  localparam logic [16:0] RATE_MAX = 17'h0FFFF;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_GUARD = 3'b001,
    TX_START = 3'b011,
    TX_DATA = 3'b010,
    TX_STOP = 3'b110
  } tx_state_t;

  typedef enum logic [1:0] {
    AB_IDLE = 2'b00,
    AB_SYNC = 2'b01,
    AB_MEAS = 2'b11
  } ab_state_t;

endpackage : serial_pkg

// File: core/serial_autorate_port.sv
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// - mode field 0x01 selects double-speed reception
// - double speed doubles rate for same divisor
// - 16 samples per bit, 8 in double
// - vote samples 8-9-10, or 4-5-6 double
// - 12+ low cycles is a break, sync follows
// - sync start runs counter eight bits, sets divisor
// - generic mode wait-for-break accepts any break length
// - generic update only for counts 0x0064..0xFFFF
// - lin mode ignores wait-for-break, needs 12 cycles
// - lin sync not 0x55 flags error, keeps divisor
// - loop-back feeds transmit pin into receiver
// - open drain never drives pin high
// - open drain makes pin output automatically
// - single wire receiver hears own frames
// - differential_transceiver_enable bit enables direction output control
// - direction high while sending, low after
// - direction rises one bit early, spans stop
// - differential_transceiver_enable and loop-back work together
// - start kept only if two of three low
// - mode field 03 selects lin auto-rate
module serial_autorate_port #(
  parameter int DATA_BITS = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire serial_pkg::axil_req_t axi_req,
  output serial_pkg::axil_rsp_t axi_rsp,
  // serial pins
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe,
  output logic transceiver_direction_output
);
  import serial_pkg::*;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_DATA: decode = SEL_DATA;
      OFS_FIRST_CTRL: decode = SEL_FIRST_CTRL;
      OFS_SECOND_CTRL: decode = SEL_SECOND_CTRL;
      OFS_STATUS: decode = SEL_STATUS;
      OFS_DIVISOR: decode = SEL_DIVISOR;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : merge

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  // registers
  logic [4:0] first_ctrl_r;
  logic [4:0] second_ctrl_r;
  logic [15:0] divisor_r;
  logic [7:0] rx_data_r;
  logic rx_valid_r;
  logic wait_for_break_bit_r;
  logic inconsistent_sync_error_flag_r;
  logic frame_err_r;

  logic loop_back_enable;
  logic differential_transceiver_enable;
  logic open_drain_enable;
  logic [1:0] receive_mode_field;
  logic rx_en;
  logic tx_en;
  assign loop_back_enable = first_ctrl_r[LOOP_BACK_BIT];
  assign differential_transceiver_enable = first_ctrl_r[XCVR_EN_BIT];
  assign receive_mode_field = second_ctrl_r[RX_MODE_LSB +: 2];
  assign open_drain_enable = second_ctrl_r[OPEN_DRAIN_BIT];
  assign rx_en = second_ctrl_r[RX_EN_BIT];
  assign tx_en = second_ctrl_r[TX_EN_BIT];

  logic double_speed;
  logic generic_autorate_mode;
  logic lin_constrained_autorate_mode;
  assign double_speed = (receive_mode_field == RECEIVE_MODE_FIELD_DOUBLE);
  assign generic_autorate_mode = (receive_mode_field == RECEIVE_MODE_FIELD_GENERIC_AUTO);
  assign lin_constrained_autorate_mode = (receive_mode_field == RECEIVE_MODE_FIELD_LIN_AUTO);

  logic [4:0] spb;
  logic [4:0] vote_first;
  assign spb = double_speed ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
  assign vote_first = double_speed ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;

  // ---------------- bus slave ----------------
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_en;
  logic rd_en;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic [31:0] rd_word;

  assign axi_rsp.awready = !aw_held_r && !bvalid_r;
  assign axi_rsp.wready = !w_held_r && !bvalid_r;
  assign axi_rsp.bvalid = bvalid_r;
  assign axi_rsp.bresp = bresp_r;
  assign axi_rsp.arready = !rvalid_r;
  assign axi_rsp.rvalid = rvalid_r;
  assign axi_rsp.rdata = rdata_r;
  assign axi_rsp.rresp = rresp_r;

  assign wr_en = aw_held_r && w_held_r && !bvalid_r;
  assign wr_sel = decode(aw_addr_r);
  assign rd_en = axi_req.arvalid && !rvalid_r;
  assign rd_sel = decode(axi_req.araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (axi_req.awvalid && !aw_held_r && !bvalid_r) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= axi_req.awaddr;
    end else if (wr_en) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (axi_req.wvalid && !w_held_r && !bvalid_r) begin
      w_held_r <= 1'b1;
      w_data_r <= axi_req.wdata;
      w_strb_r <= axi_req.wstrb;
    end else if (wr_en) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (axi_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------- rate tick ----------------
  logic [16:0] acc_r;
  logic [16:0] acc_sum;
  logic tick;
  assign acc_sum = acc_r + ACC_STEP;
  assign tick = (acc_sum >= {1'b0, divisor_r});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= '0;
    end else if (tick) begin
      acc_r <= acc_sum - {1'b0, divisor_r};
    end else begin
      acc_r <= acc_sum;
    end
  end

  // ---------------- pin synchronisers ----------------
  logic rxd_s1_r;
  logic rxd_s2_r;
  logic txd_s1_r;
  logic txd_s2_r;
  logic rx_line;
  logic line_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      txd_s1_r <= 1'b1;
      txd_s2_r <= 1'b1;
      line_prev_r <= 1'b1;
    end else begin
      rxd_s1_r <= rxd_i;
      rxd_s2_r <= rxd_s1_r;
      txd_s1_r <= txd_i;
      txd_s2_r <= txd_s1_r;
      line_prev_r <= rx_line;
    end
  end

  // shared line: with loop-back set, receiver listens to the transmit pin itself
  assign rx_line = loop_back_enable ? txd_s2_r : rxd_s2_r;

  // ---------------- auto-rate ----------------
  ab_state_t ab_st_r;
  logic [3:0] low_cnt_r;
  logic [16:0] ab_cnt_r;
  logic [16:0] intv_r;
  logic [16:0] first_intv_r;
  logic [3:0] edges_r;
  logic [2:0] falls_r;
  logic ab_bad_r;
  logic auto_mode;
  logic rise;
  logic fall;
  logic break_seen;
  logic ab_finish;
  logic ab_load;
  logic ab_sync_err;
  logic intv_off;
  logic [18:0] intv2;
  logic [18:0] first3;

  assign auto_mode = generic_autorate_mode || lin_constrained_autorate_mode;
  assign rise = rx_line && !line_prev_r;
  assign fall = !rx_line && line_prev_r;
  assign break_seen = auto_mode && rise && ((low_cnt_r >= BREAK_MIN)
    || (generic_autorate_mode && wait_for_break_bit_r));
  assign ab_finish = (ab_st_r == AB_MEAS) && fall && (falls_r == SYNC_FALLS - 3'h1);
  assign intv2 = {1'b0, intv_r, 1'b0};
  assign first3 = {2'b00, first_intv_r} + {1'b0, first_intv_r, 1'b0};
  assign intv_off = (edges_r != 4'h0)
    && ((intv2 < {2'b00, first_intv_r}) || (intv2 > first3));
  assign ab_load = ab_finish && (generic_autorate_mode
    ? (ab_cnt_r >= RATE_MIN && ab_cnt_r <= RATE_MAX)
    : (!ab_bad_r && !intv_off && ab_cnt_r <= RATE_MAX));
  assign ab_sync_err = ab_finish && lin_constrained_autorate_mode
    && (ab_bad_r || intv_off || ab_cnt_r > RATE_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r <= '0;
    end else if (rx_line) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != 4'hF) begin
      low_cnt_r <= low_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !auto_mode) begin
      ab_st_r <= AB_IDLE;
      ab_cnt_r <= '0;
      intv_r <= '0;
      first_intv_r <= '0;
      edges_r <= '0;
      falls_r <= '0;
      ab_bad_r <= 1'b0;
    end else begin
      case (ab_st_r)
        AB_IDLE: begin
          if (break_seen) begin
            ab_st_r <= AB_SYNC;
          end
        end
        AB_SYNC: begin
          if (fall) begin
            ab_st_r <= AB_MEAS;
            ab_cnt_r <= 17'h00001;
            intv_r <= 17'h00001;
            edges_r <= '0;
            falls_r <= '0;
            ab_bad_r <= 1'b0;
          end
        end
        AB_MEAS: begin
          if (ab_cnt_r <= RATE_MAX) begin
            ab_cnt_r <= ab_cnt_r + 17'h00001;
          end
          if (rise || fall) begin
            intv_r <= 17'h00001;
            edges_r <= edges_r + 4'h1;
            if (edges_r == 4'h0) begin
              first_intv_r <= intv_r;
            end
            if (intv_off) begin
              ab_bad_r <= 1'b1;
            end
            if (fall) begin
              falls_r <= falls_r + 3'h1;
            end
          end else if (intv_r <= RATE_MAX) begin
            intv_r <= intv_r + 17'h00001;
          end
          if (ab_finish) begin
            ab_st_r <= AB_IDLE;
          end
        end
        default: ab_st_r <= AB_IDLE;
      endcase
    end
  end

  // ---------------- receiver ----------------
  rx_state_t rx_st_r;
  logic [4:0] rx_cnt_r;
  logic [1:0] vote_r;
  logic [3:0] rx_idx_r;
  logic [7:0] rx_shift_r;
  logic rx_done_r;
  logic rx_ferr_r;
  logic bit_val;
  logic ab_busy;
  assign ab_busy = (ab_st_r != AB_IDLE) || break_seen;
  assign bit_val = maj3(vote_r[1], vote_r[0], rx_line);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= '0;
      vote_r <= '0;
      rx_idx_r <= '0;
      rx_shift_r <= '0;
      rx_done_r <= 1'b0;
      rx_ferr_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (ab_busy || !rx_en) begin
        rx_st_r <= RX_IDLE;
      end else if (tick) begin
        if (rx_st_r == RX_IDLE) begin
          if (!rx_line) begin
            rx_st_r <= RX_START;
            rx_cnt_r <= 5'h01;
          end
        end else begin
          rx_cnt_r <= (rx_cnt_r == spb) ? 5'h01 : rx_cnt_r + 5'h01;
          if (rx_cnt_r == vote_first || rx_cnt_r == vote_first + 5'h01) begin
            vote_r <= {vote_r[0], rx_line};
          end
          if (rx_cnt_r == vote_first + 5'h02) begin
            case (rx_st_r)
              RX_START: begin
                rx_st_r <= bit_val ? RX_IDLE : RX_DATA;
                rx_idx_r <= '0;
              end
              RX_DATA: begin
                rx_shift_r <= {bit_val, rx_shift_r[7:1]};
                rx_idx_r <= rx_idx_r + 4'h1;
                if (rx_idx_r == 4'(DATA_BITS - 1)) begin
                  rx_st_r <= RX_STOP;
                end
              end
              default: begin
                rx_st_r <= RX_IDLE;
                rx_done_r <= 1'b1;
                rx_ferr_r <= !bit_val;
              end
            endcase
          end
        end
      end
    end
  end

  // ---------------- transmitter ----------------
  tx_state_t tx_st_r;
  logic [4:0] tx_cnt_r;
  logic [3:0] tx_idx_r;
  logic [7:0] tx_shift_r;
  logic tx_bit_r;
  logic tx_go;
  logic bit_end;
  assign tx_go = wr_en && (wr_sel == SEL_DATA) && w_strb_r[0] && tx_en && (tx_st_r == TX_IDLE);
  assign bit_end = tick && (tx_cnt_r == spb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= '0;
      tx_idx_r <= '0;
      tx_shift_r <= '0;
      tx_bit_r <= 1'b1;
    end else begin
      if (tick) begin
        tx_cnt_r <= (tx_cnt_r == spb) ? 5'h01 : tx_cnt_r + 5'h01;
      end
      case (tx_st_r)
        TX_IDLE: begin
          tx_bit_r <= 1'b1;
          if (tx_go) begin
            tx_shift_r <= w_data_r[7:0];
            tx_cnt_r <= 5'h01;
            // guard bit only ahead of an external driver
            tx_st_r <= differential_transceiver_enable ? TX_GUARD : TX_START;
            tx_bit_r <= differential_transceiver_enable;
          end
        end
        TX_GUARD: if (bit_end) begin
          tx_st_r <= TX_START;
          tx_bit_r <= 1'b0;
        end
        TX_START: if (bit_end) begin
          tx_st_r <= TX_DATA;
          tx_idx_r <= '0;
          tx_bit_r <= tx_shift_r[0];
          tx_shift_r <= {1'b1, tx_shift_r[7:1]};
        end
        TX_DATA: if (bit_end) begin
          tx_idx_r <= tx_idx_r + 4'h1;
          if (tx_idx_r == 4'(DATA_BITS - 1)) begin
            tx_st_r <= TX_STOP;
            tx_bit_r <= 1'b1;
          end else begin
            tx_bit_r <= tx_shift_r[0];
            tx_shift_r <= {1'b1, tx_shift_r[7:1]};
          end
        end
        TX_STOP: if (bit_end) begin
          tx_st_r <= TX_IDLE;
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // start bit must leave from the next state, so drive start level on entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_o <= 1'b1;
      txd_oe <= 1'b0;
      transceiver_direction_output <= 1'b0;
    end else begin
      txd_o <= open_drain_enable ? 1'b0 : tx_bit_r;
      txd_oe <= open_drain_enable ? !tx_bit_r : tx_en;
      transceiver_direction_output <= differential_transceiver_enable
        && (tx_st_r != TX_IDLE);
    end
  end

  // ---------------- register file ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_ctrl_r <= FIRST_CTRL_RESET;
      second_ctrl_r <= SECOND_CTRL_RESET;
    end else if (wr_en && w_strb_r[0]) begin
      if (wr_sel == SEL_FIRST_CTRL) begin
        first_ctrl_r <= {3'h0, w_data_r[XCVR_EN_BIT], w_data_r[LOOP_BACK_BIT]};
      end
      if (wr_sel == SEL_SECOND_CTRL) begin
        second_ctrl_r <= w_data_r[4:0];
      end
    end
  end

  logic [31:0] div_merged;
  assign div_merged = merge({16'h0000, divisor_r}, w_data_r, w_strb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divisor_r <= DIVISOR_RESET;
    end else if (ab_load) begin
      divisor_r <= ab_cnt_r[15:0];
    end else if (wr_en && wr_sel == SEL_DIVISOR) begin
      divisor_r <= div_merged[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_r <= '0;
      rx_valid_r <= 1'b0;
      frame_err_r <= 1'b0;
    end else if (rx_done_r) begin
      rx_data_r <= rx_shift_r;
      rx_valid_r <= 1'b1;
      frame_err_r <= rx_ferr_r || frame_err_r;
    end else begin
      if (rd_en && rd_sel == SEL_DATA) begin
        rx_valid_r <= 1'b0;
      end
      if (wr_en && wr_sel == SEL_STATUS && w_strb_r[0] && w_data_r[ST_FRAME_ERR_BIT]) begin
        frame_err_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_for_break_bit_r <= 1'b0;
      inconsistent_sync_error_flag_r <= 1'b0;
    end else begin
      if (wr_en && wr_sel == SEL_STATUS && w_strb_r[0] && w_data_r[ST_WAIT_BREAK_BIT]) begin
        wait_for_break_bit_r <= 1'b1;
      end else if (break_seen && ab_st_r == AB_IDLE) begin
        wait_for_break_bit_r <= 1'b0;
      end
      if (ab_sync_err) begin
        inconsistent_sync_error_flag_r <= 1'b1;
      end else if (wr_en && wr_sel == SEL_STATUS && w_strb_r[0]
                   && w_data_r[ST_SYNC_ERR_BIT]) begin
        inconsistent_sync_error_flag_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (rd_sel)
      SEL_DATA: rd_word = {23'h000000, rx_valid_r, rx_data_r};
      SEL_FIRST_CTRL: rd_word = {27'h0000000, first_ctrl_r};
      SEL_SECOND_CTRL: rd_word = {27'h0000000, second_ctrl_r};
      SEL_STATUS: begin
        rd_word[ST_RX_VALID_BIT] = rx_valid_r;
        rd_word[ST_TX_BUSY_BIT] = (tx_st_r != TX_IDLE);
        rd_word[ST_WAIT_BREAK_BIT] = wait_for_break_bit_r;
        rd_word[ST_SYNC_ERR_BIT] = inconsistent_sync_error_flag_r;
        rd_word[ST_FRAME_ERR_BIT] = frame_err_r;
      end
      SEL_DIVISOR: rd_word = {16'h0000, divisor_r};
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (rd_en) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : serial_autorate_port
